/* bench/eid_bench.sv */
`timescale 1ns/1ps
module eid_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic        stop_mode_i = 1'b0;
    logic        drv_en = 1'b0;
    logic        drv_val = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, pin_i, wake_o, pull_up_en_o, pull_down_en_o;
    logic        pin_level_o, cpu_irq_o, irq_o;
    int          fail_count = 0;
    int          checks_done = 0;
    // Bench clock at 25 MHz.
    always #20 clk_i = ~clk_i;
    eid_top dut (.*);
    eid_pin_source u_src (.clk_i(clk_i), .drv_en(drv_en), .drv_val(drv_val),
        .pu_i(pull_up_en_o), .pd_i(pull_down_en_o), .pin_o(pin_i));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle, held until ack is seen.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic t_route;
        rd(8'h04, 32'h0); rd(8'h1C, 32'h0);
        wr(8'h04, 32'h4); wr(8'h00, 32'h10); tick(1);
        chk({pull_up_en_o, pull_down_en_o}, 2'h2);
        wr(8'h00, 32'h30); tick(1);
        chk({pull_up_en_o, pull_down_en_o}, 2'h1);
        wr(8'h00, 32'h50); tick(1);
        chk({pull_up_en_o, pull_down_en_o}, 2'h0);
        wr(8'h04, 32'h3); wr(8'h00, 32'h10); tick(1);
        chk(pull_up_en_o, 1'b0);
        wr(8'h04, 32'h4); wr(8'h00, 32'h0); tick(1);
        chk(pull_up_en_o, 1'b0);
    endtask
    task automatic t_edge;
        wr(8'h00, 32'h10); tick(8); wr(8'h00, 32'h14); wr(8'h08, 32'h3); wr(8'h00, 32'h11);
        tick(6); drv_en <= 1'b1; drv_val <= 1'b0; tick(8);
        rd(8'h00, 32'h13);
        chk(cpu_irq_o, 1'b1);
        wr(8'h00, 32'h15);
        rd(8'h00, 32'h11);
        chk(cpu_irq_o, 1'b0);
        rd(8'h08, 32'h1); wr(8'h0C, 32'h1); tick(1);
        chk(irq_o, 1'b1); wr(8'h08, 32'h1); tick(1);
        chk(irq_o, 1'b0); wr(8'h0C, 32'h0);
    endtask
    task automatic t_level;
        wr(8'h00, 32'h19); tick(3); wr(8'h00, 32'h1D); tick(1);
        rd(8'h00, 32'h1B);
        drv_en <= 1'b0; tick(8); wr(8'h00, 32'h1D);
        rd(8'h00, 32'h19);
    endtask
    task automatic t_poll_wake;
        wr(8'h00, 32'h10); wr(8'h00, 32'h14);
        drv_en <= 1'b1; tick(8);
        rd(8'h00, 32'h12);
        chk(cpu_irq_o, 1'b0);
        stop_mode_i <= 1'b1; tick(2);
        chk({wake_o, pin_level_o}, 2'h2);
        drv_en <= 1'b0; tick(8);
        chk({wake_o, pin_level_o}, 2'h1);
        stop_mode_i <= 1'b0; rd(8'h08, 32'h3); wr(8'h08, 32'h3); rd(8'h08, 32'h0);
    endtask
    task automatic close_out;
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Sequence of scenarios after reset.
    initial begin
        tick(16); rst_i <= 1'b0; tick(1);
        t_route(); t_edge(); t_level(); t_poll_wake();
        close_out();
    end
    // Cuts a hang short.
    initial begin
        tick(20000); fail_count++; close_out();
    end
endmodule // eid_bench

/* bench/eid_pin_source.sv */
`timescale 1ns/1ps
// Outside source on the pin: drives it, or leaves it to the pull devices.
module eid_pin_source (
    input  wire logic clk_i,   // Bench clock.
    input  wire logic drv_en,  // Source drives the pin.
    input  wire logic drv_val, // Driven level.
    input  wire logic pu_i,    // Pull-up engaged.
    input  wire logic pd_i,    // Pull-down engaged.
    output logic      pin_o    // Pin level.
);
    logic float_r = 1'b0;
    // A pin with nobody driving or pulling wanders rather than keeping a level.
    always_ff @(posedge clk_i) begin
        float_r <= ~float_r;
    end
    assign pin_o = drv_en ? drv_val : pu_i ? 1'b1 : pd_i ? 1'b0 : float_r;
endmodule // eid_pin_source

/* bench/eid_top_asserts.sv */
`timescale 1ns/1ps
// Watches the pin detector from its ports alone.
module eid_top_asserts (
    input wire logic        clk_i,          // Clock.
    input wire logic        rst_i,          // Reset.
    input wire logic        wb_stb_i,       // Strobe.
    input wire logic        wb_we_i,        // Write.
    input wire logic [7:0]  wb_adr_i,       // Address.
    input wire logic [31:0] wb_dat_i,       // Write data.
    input wire logic        wb_ack_o,       // Acknowledge.
    input wire logic        pin_i,          // Pin.
    input wire logic        stop_mode_i,    // Stop mode.
    input wire logic        wake_o,         // Wake.
    input wire logic        pull_up_en_o,   // Pull-up.
    input wire logic        pull_down_en_o, // Pull-down.
    input wire logic        pin_level_o,    // Pin level.
    input wire logic        cpu_irq_o       // CPU request.
);
    logic ie_r;
    // Shadow of the interrupt enable, taken at each control write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ie_r <= 1'b0;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00) begin
            ie_r <= wb_dat_i[0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_high;
        (pull_up_en_o && ie_r && pin_i && !wb_stb_i)[*5];
    endsequence
    sequence s_low;
        (pull_up_en_o && ie_r && !pin_i && !wb_stb_i)[*7];
    endsequence
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("stray ack");
    a_pull_exclusive: assert property (!(pull_up_en_o && pull_down_en_o))
        else $error("both pulls on");
    a_wake_low: assert property (stop_mode_i && pull_up_en_o && !pin_i |-> wake_o)
        else $error("no wake on low");
    a_wake_high: assert property (stop_mode_i && pull_down_en_o && pin_i |-> wake_o)
        else $error("no wake on high");
    a_irq_enable: assert property (cpu_irq_o |-> ie_r) else $error("request unenabled");
    a_level_seen: assert property ((pull_up_en_o && pin_i)[*6] |-> pin_level_o)
        else $error("level not shown");
    a_edge_flag: assert property (s_high ##1 s_low |-> cpu_irq_o)
        else $error("edge missed");
endmodule // eid_top_asserts
bind eid_top eid_top_asserts u_chk (.*);

/* src/eid_pin_sync.sv */
`timescale 1ns/1ps
// Three-stage pin synchroniser; the level changes once stages two and three agree.
module eid_pin_sync (
    input  wire logic clk_i,   // Bus clock.
    input  wire logic rst_i,   // Synchronous reset, active high.
    input  wire logic pin_i,   // Raw pin level.
    output logic      level_o  // Settled pin level.
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } eid_sync_state_t;

    eid_sync_state_t st_r;
    eid_sync_state_t st_nxt;

    // Shift the pin through the stages and accept a level that two stages agree on.
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.level = st_r.s3;
        end
    end

    // Register the state; the pin idles high after reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.level;
endmodule // eid_pin_sync

/* src/eid_pkg.sv */
package eid_pkg;
    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_FUNCTION_SEL   = 8'h04;
    localparam logic [7:0] ADDR_INT_STATUS     = 8'h08;
    localparam logic [7:0] ADDR_INT_MASK       = 8'h0C;
    localparam logic [7:0] ADDR_PIN_LEVEL      = 8'h10;

    // Bit positions in the status/control register.
    localparam int BIT_INT_ENABLE   = 0;
    localparam int BIT_EVENT_FLAG   = 1;
    localparam int BIT_ACKNOWLEDGE  = 2;
    localparam int BIT_LEVEL_MODE   = 3;
    localparam int BIT_FUNC_ENABLE  = 4;
    localparam int BIT_POLARITY     = 5;
    localparam int BIT_PULL_DISABLE = 6;

    // Bit positions in the interrupt status and mask registers.
    localparam int BIT_INT_EVENT = 0;
    localparam int BIT_INT_WAKE  = 1;
    localparam int INT_BITS      = 2;

    // Pin-five function field in the function-select register.
    localparam int FUNC_LSB   = 0;
    localparam int FUNC_WIDTH = 4;
    localparam logic [3:0] FUNC_EXT_INT = 4'h4;

    // Reset values.
    localparam logic [3:0] FUNC_RESET = 4'h0;
    localparam logic [1:0] INT_RESET  = 2'h0;
    localparam logic       CTRL_RESET = 1'b0;
endpackage

/* src/eid_top.sv */
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - Pin routes to interrupt logic only when its function field holds 0100b.
// - Clocked logic samples the pin, detecting edges or edges and levels.
// - In stop mode an enabled pin wakes the device through an unclocked path.
// - Pin acts as interrupt input only while the function enable bit is one.
// - Polarity bit picks the asserted edge direction and level.
// - Mode bit selects edges only, or edges plus sustained asserted levels.
// - Events always set the flag; a request needs the interrupt enable too.
// - Enabled pin with pull disable zero engages a pull matching polarity.
// - Pull disable set to one switches the internal pull device off.
// - Pin level is offered to branch-on-level instructions while configured.
// - In level mode a deasserted-to-asserted move sets the event flag.
// - In level mode the flag stays set and unclearable while pin asserted.
// - Writing the acknowledge bit clears a pending event flag.
// - CPU request is raised while the flag and interrupt enable are set.
module eid_top (
    input  wire logic        clk_i,          // Bus clock, 25 MHz.
    input  wire logic        rst_i,          // Synchronous reset, active high.
    input  wire logic        wb_cyc_i,       // Wishbone cycle.
    input  wire logic        wb_stb_i,       // Wishbone strobe.
    input  wire logic        wb_we_i,        // Wishbone write enable.
    input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address.
    input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects.
    input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
    output logic [31:0]      wb_dat_o,       // Wishbone read data.
    output logic             wb_ack_o,       // Wishbone acknowledge.
    input  wire logic        pin_i,          // External interrupt pin.
    input  wire logic        stop_mode_i,    // Clocks halted for stop mode.
    output logic             wake_o,         // Asynchronous wake request.
    output logic             pull_up_en_o,   // Internal pull-up enable.
    output logic             pull_down_en_o, // Internal pull-down enable.
    output logic             pin_level_o,    // Pin level for branch tests.
    output logic             cpu_irq_o,      // Interrupt request to the CPU.
    output logic             irq_o           // Masked sticky interrupt, level.
);
    typedef struct packed {
        logic        int_enable;
        logic        event_flag;
        logic        level_mode;
        logic        func_enable;
        logic        polarity;
        logic        pull_disable;
        logic [3:0]  func_field;
        logic [1:0]  int_status;
        logic [1:0]  int_mask;
        logic        asserted_prev;
        logic        wake_prev;
        logic        ack;
        logic [31:0] rdata;
    } eid_state_t;

    eid_state_t st_r;
    eid_state_t st_nxt;
    logic       level_sync;
    logic       pin_enabled;
    logic       asserted;
    logic       edge_event;
    logic       flag_set;
    logic       bus_req;
    logic       bus_write;
    logic       ack_write;

    // Bring the pin into the bus clock domain.
    // pin synchroniser
    eid_pin_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (pin_i),
        .level_o (level_sync)
    );

    // Converts the settled level into an asserted indication for the chosen polarity.
    function automatic logic is_asserted(input logic level, input logic pol);
        return pol ? level : ~level;
    endfunction

    // Pin routing and event detection.
    // function field gate
    assign pin_enabled = (st_r.func_field == eid_pkg::FUNC_EXT_INT) && st_r.func_enable;
    assign asserted    = is_asserted(level_sync, st_r.polarity);
    assign edge_event  = pin_enabled && asserted && !st_r.asserted_prev;
    assign flag_set    = edge_event || (pin_enabled && st_r.level_mode && asserted);

    // Bus request decoding.
    assign bus_req   = wb_cyc_i && wb_stb_i;
    assign bus_write = bus_req && wb_we_i && st_r.ack && wb_sel_i[0];
    assign ack_write = bus_write && (wb_adr_i == eid_pkg::ADDR_STATUS_CONTROL)
                       && wb_dat_i[eid_pkg::BIT_ACKNOWLEDGE];

    // Next-state logic for registers, flags and the bus slave.
    always_comb begin
        st_nxt               = st_r;
        st_nxt.asserted_prev = asserted;
        st_nxt.wake_prev     = wake_o;
        st_nxt.ack           = bus_req && !st_r.ack;

        // Read data is captured in the cycle the acknowledge rises.
        st_nxt.rdata = 32'h0000_0000;
        if (bus_req && !st_r.ack && !wb_we_i) begin
            case (wb_adr_i)
                eid_pkg::ADDR_STATUS_CONTROL: begin
                    st_nxt.rdata[eid_pkg::BIT_INT_ENABLE]   = st_r.int_enable;
                    st_nxt.rdata[eid_pkg::BIT_EVENT_FLAG]   = st_r.event_flag;
                    st_nxt.rdata[eid_pkg::BIT_LEVEL_MODE]   = st_r.level_mode;
                    st_nxt.rdata[eid_pkg::BIT_FUNC_ENABLE]  = st_r.func_enable;
                    st_nxt.rdata[eid_pkg::BIT_POLARITY]     = st_r.polarity;
                    st_nxt.rdata[eid_pkg::BIT_PULL_DISABLE] = st_r.pull_disable;
                end
                eid_pkg::ADDR_FUNCTION_SEL: begin
                    st_nxt.rdata[eid_pkg::FUNC_LSB +: eid_pkg::FUNC_WIDTH] = st_r.func_field;
                end
                eid_pkg::ADDR_INT_STATUS: begin
                    st_nxt.rdata[eid_pkg::INT_BITS-1:0] = st_r.int_status;
                end
                eid_pkg::ADDR_INT_MASK: begin
                    st_nxt.rdata[eid_pkg::INT_BITS-1:0] = st_r.int_mask;
                end
                eid_pkg::ADDR_PIN_LEVEL: begin
                    st_nxt.rdata[0] = level_sync;
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Writes take effect at the edge where the acknowledge is high.
        if (bus_write) begin
            case (wb_adr_i)
                eid_pkg::ADDR_STATUS_CONTROL: begin
                    st_nxt.int_enable   = wb_dat_i[eid_pkg::BIT_INT_ENABLE];
                    st_nxt.level_mode   = wb_dat_i[eid_pkg::BIT_LEVEL_MODE];
                    st_nxt.func_enable  = wb_dat_i[eid_pkg::BIT_FUNC_ENABLE];
                    st_nxt.polarity     = wb_dat_i[eid_pkg::BIT_POLARITY];
                    st_nxt.pull_disable = wb_dat_i[eid_pkg::BIT_PULL_DISABLE];
                end
                eid_pkg::ADDR_FUNCTION_SEL: begin
                    st_nxt.func_field = wb_dat_i[eid_pkg::FUNC_LSB +: eid_pkg::FUNC_WIDTH];
                end
                eid_pkg::ADDR_INT_STATUS: begin
                    st_nxt.int_status = st_r.int_status & ~wb_dat_i[eid_pkg::INT_BITS-1:0];
                end
                eid_pkg::ADDR_INT_MASK: begin
                    st_nxt.int_mask = wb_dat_i[eid_pkg::INT_BITS-1:0];
                end
                default: begin
                    st_nxt.int_mask = st_r.int_mask;
                end
            endcase
        end

        if (ack_write) begin
            st_nxt.event_flag = 1'b0;
        end
        if (flag_set) begin
            st_nxt.event_flag = 1'b1;
        end

        // Sticky interrupt status; a new event wins over a clear.
        if (edge_event) begin
            st_nxt.int_status[eid_pkg::BIT_INT_EVENT] = 1'b1;
        end
        if (wake_o && !st_r.wake_prev) begin
            st_nxt.int_status[eid_pkg::BIT_INT_WAKE] = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{
                int_enable:    eid_pkg::CTRL_RESET,
                event_flag:    eid_pkg::CTRL_RESET,
                level_mode:    eid_pkg::CTRL_RESET,
                func_enable:   eid_pkg::CTRL_RESET,
                polarity:      eid_pkg::CTRL_RESET,
                pull_disable:  eid_pkg::CTRL_RESET,
                func_field:    eid_pkg::FUNC_RESET,
                int_status:    eid_pkg::INT_RESET,
                int_mask:      eid_pkg::INT_RESET,
                asserted_prev: 1'b0,
                wake_prev:     1'b0,
                ack:           1'b0,
                rdata:         32'h0000_0000
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // Unclocked wake path from the raw pin, usable with clocks halted.
    // asynchronous wake
    assign wake_o = pin_enabled && stop_mode_i && is_asserted(pin_i, st_r.polarity);

    // Pull device control follows polarity unless disabled.
    // pull matches polarity
    assign pull_up_en_o   = pin_enabled && !st_r.pull_disable && !st_r.polarity;
    assign pull_down_en_o = pin_enabled && !st_r.pull_disable && st_r.polarity;

    assign pin_level_o = pin_enabled && level_sync;

    assign cpu_irq_o = st_r.event_flag && st_r.int_enable;
    assign irq_o     = |(st_r.int_status & st_r.int_mask);

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdata;
endmodule // eid_top
